//--- verilog/uafd_device.sv
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "uafd_defs.svh"
module uafd_device #(
    parameter int DIV_W = 16
) (
    uafd_if.device link,
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [DIV_W-1:0] i_baud_divisor,
    input wire logic i_double_speed_select,
    input wire logic [2:0] i_char_size_code,
    input wire logic i_stop_bit_select,
    input wire logic i_address_filter_mode,
    input wire logic i_rx_en,
    input wire logic i_tx_en,
    input wire logic i_dp_wr,
    input wire logic [7:0] i_dp_wdata,
    input wire logic i_tx_ninth_bit,
    input wire logic i_dp_rd,
    input wire logic i_txc_clear,
    output logic [7:0] o_dp_rdata,
    output logic o_rx_ninth_bit,
    output logic o_receive_complete,
    output logic o_data_reg_empty_flag,
    output logic o_transmit_complete_flag,
    output logic o_frame_error,
    output logic o_data_overrun
);
    logic [DIV_W-1:0] div_cnt_q;
    logic tick;
    logic [4:0] s_len;
    logic [4:0] s_first;
    logic [3:0] nbits;
    logic rx_in;

    assign tick = (div_cnt_q == '0);
    assign s_len = i_double_speed_select ? `UAFD_SAMPLES_DBL : `UAFD_SAMPLES_NORM;
    assign s_first = i_double_speed_select ? `UAFD_VOTE_FIRST_DBL : `UAFD_VOTE_FIRST_NORM;
    assign nbits = uafd_pkg::uafd_data_bits(i_char_size_code);
    assign rx_in = link.node_to_dev;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            div_cnt_q <= '0;
        end else if (tick) begin
            div_cnt_q <= i_baud_divisor;
        end else begin
            div_cnt_q <= div_cnt_q - 1'b1;
        end
    end

    // receiver
    uafd_pkg::uafd_rx_state_type rst_q;
    logic rx_prev_q;
    logic [4:0] rsamp_q;
    logic [3:0] rbit_q;
    logic [1:0] vote_q;
    logic [8:0] rdata_q;
    logic vote_end;
    logic maj;
    logic frame_done;
    logic type_bit;
    logic accept;

    assign vote_end = tick && (rsamp_q == s_first + `UAFD_VOTE_SPAN);
    assign maj = uafd_pkg::uafd_majority(vote_q[1], vote_q[0], rx_in);
    assign frame_done = vote_end && (rst_q == uafd_pkg::RX_STOP);
    assign type_bit = (nbits == `UAFD_NINE_BITS) ? rdata_q[`UAFD_NINTH_IDX] : maj;
    // only data frames (type zero) are dropped, and only while filtering
    assign accept = frame_done && !(i_address_filter_mode && !type_bit);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || !i_rx_en) begin
            rst_q <= uafd_pkg::RX_IDLE;
            rx_prev_q <= 1'b1;
            rsamp_q <= `UAFD_SAMPLE_FIRST;
            rbit_q <= '0;
            vote_q <= '0;
            rdata_q <= '0;
        end else if (tick) begin
            rx_prev_q <= rx_in;
            rsamp_q <= (rsamp_q == s_len) ? `UAFD_SAMPLE_FIRST : rsamp_q + `UAFD_SAMPLE_STEP;
            if (rsamp_q >= s_first && rsamp_q < s_first + `UAFD_VOTE_SPAN) begin
                vote_q <= {vote_q[0], rx_in};
            end
            unique case (rst_q)
                uafd_pkg::RX_IDLE: begin
                    // the first low sample counts as sample one
                    if (rx_prev_q && !rx_in) begin
                        rst_q <= uafd_pkg::RX_START;
                        rsamp_q <= `UAFD_SAMPLE_FIRST + `UAFD_SAMPLE_STEP;
                    end else begin
                        rsamp_q <= `UAFD_SAMPLE_FIRST;
                    end
                end
                uafd_pkg::RX_START: begin
                    if (vote_end) begin
                        if (maj) begin
                            rst_q <= uafd_pkg::RX_IDLE;
                        end
                    end else if (rsamp_q == s_len) begin
                        rst_q <= uafd_pkg::RX_BITS;
                        rbit_q <= '0;
                        rdata_q <= '0;
                    end
                end
                uafd_pkg::RX_BITS: begin
                    if (vote_end) begin
                        rdata_q[rbit_q] <= maj;
                    end else if (rsamp_q == s_len) begin
                        if (rbit_q == nbits - 4'h1) begin
                            rst_q <= uafd_pkg::RX_STOP;
                        end else begin
                            rbit_q <= rbit_q + 4'h1;
                        end
                    end
                end
                uafd_pkg::RX_STOP: begin
                    // leave right after the stop vote so an early next start is caught
                    if (vote_end) begin
                        rst_q <= uafd_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    // two-entry receive FIFO; entry 0 is always the head so read data comes from flops
    uafd_pkg::uafd_rx_entry_type ent_q [0:1];
    logic [1:0] count_q;
    logic pop;
    logic push;
    logic [1:0] wpos;
    logic dor_q;

    assign pop = i_dp_rd && (count_q != 2'h0);
    assign push = accept && ((count_q != `UAFD_RXFIFO_DEPTH) || pop);
    assign wpos = count_q - {1'b0, pop};

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || !i_rx_en) begin
            count_q <= '0;
            ent_q[0] <= '0;
            ent_q[1] <= '0;
        end else begin
            if (pop) begin
                ent_q[0] <= ent_q[1];
            end
            if (push) begin
                ent_q[wpos[0]] <= '{fe: !maj, data: rdata_q};
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // a frame that finds the FIFO full with no read in the same cycle is lost; a new loss wins over the clearing read
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || !i_rx_en) begin
            dor_q <= 1'b0;
        end else if (accept && !push) begin
            dor_q <= 1'b1;
        end else if (pop) begin
            dor_q <= 1'b0;
        end
    end

    assign o_receive_complete = (count_q != 2'h0);
    assign o_dp_rdata = ent_q[0].data[7:0];
    assign o_rx_ninth_bit = ent_q[0].data[`UAFD_NINTH_IDX];
    assign o_frame_error = ent_q[0].fe && o_receive_complete;
    assign o_data_overrun = dor_q;

    // transmitter; nothing here looks at the filter mode
    uafd_pkg::uafd_tx_state_type tst_q;
    logic [8:0] tbuf_q;
    logic tbuf_full_q;
    logic [8:0] tsh_q;
    logic [4:0] tsamp_q;
    logic [3:0] tbit_q;
    logic [3:0] tlast;
    logic txd_q;
    logic txc_q;
    logic wr_ok;
    logic load;
    logic bit_end;
    logic tx_end;

    assign wr_ok = i_dp_wr && !tbuf_full_q;
    assign load = tbuf_full_q && i_tx_en && (tst_q == uafd_pkg::TX_IDLE);
    assign tlast = nbits + {3'h0, i_stop_bit_select};
    assign bit_end = tick && (tsamp_q == s_len);
    assign tx_end = bit_end && (tst_q == uafd_pkg::TX_BITS) && (tbit_q == tlast) && !tbuf_full_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            tbuf_full_q <= 1'b0;
            tbuf_q <= '0;
        end else if (wr_ok) begin
            tbuf_full_q <= 1'b1;
            tbuf_q <= {i_tx_ninth_bit, i_dp_wdata} & uafd_pkg::uafd_char_mask(nbits);
        end else if (load) begin
            tbuf_full_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            tst_q <= uafd_pkg::TX_IDLE;
            tsh_q <= '0;
            tsamp_q <= `UAFD_SAMPLE_FIRST;
            tbit_q <= '0;
            txd_q <= 1'b1;
        end else if (load) begin
            tst_q <= uafd_pkg::TX_START;
            tsh_q <= tbuf_q;
            tsamp_q <= `UAFD_SAMPLE_FIRST;
            txd_q <= 1'b0;
        end else if (tick) begin
            tsamp_q <= (tsamp_q == s_len) ? `UAFD_SAMPLE_FIRST : tsamp_q + `UAFD_SAMPLE_STEP;
            if (tsamp_q == s_len) begin
                unique case (tst_q)
                    uafd_pkg::TX_IDLE: begin
                        txd_q <= 1'b1;
                    end
                    uafd_pkg::TX_START: begin
                        tst_q <= uafd_pkg::TX_BITS;
                        tbit_q <= '0;
                        txd_q <= uafd_pkg::uafd_frame_bit(tsh_q, nbits, 4'h0, 1'b0);
                    end
                    uafd_pkg::TX_BITS: begin
                        if (tbit_q == tlast) begin
                            tst_q <= uafd_pkg::TX_IDLE;
                        end else begin
                            tbit_q <= tbit_q + 4'h1;
                            txd_q <= uafd_pkg::uafd_frame_bit(tsh_q, nbits, tbit_q + 4'h1, 1'b0);
                        end
                    end
                    default: begin
                        tst_q <= uafd_pkg::TX_IDLE;
                    end
                endcase
            end
        end
    end

    // set wins over the clearing write
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            txc_q <= 1'b0;
        end else if (tx_end) begin
            txc_q <= 1'b1;
        end else if (i_txc_clear) begin
            txc_q <= 1'b0;
        end
    end

    assign link.dev_to_node = txd_q;
    assign o_data_reg_empty_flag = !tbuf_full_q;
    assign o_transmit_complete_flag = txc_q;
endmodule
`default_nettype wire

//--- shared/uafd_defs.svh
// Operation
// - oversample 16x normal, 8x double speed
// - voting starts sample 8/4, middle 9/5
// - normal 8-bit frames tolerate 95.36-104.58 percent
// - sender keeps own rate error near half
// - filter mode drops data frames entirely
// - transmitter ignores the filter mode setting
// - type bit: first stop, or ninth bit
// - type one is address, zero is data
// - address frames stored and flagged as normal
// - filter cleared means all frames accepted
// - master sends nine-bit frames, ninth marks address
// - short frames need two stop bits sent
// - one data port: write transmits, read receives
// - short characters: upper bits ignored or zero
// - write while buffer full is ignored
// - buffer moves to shifter once shifter empty
// - two-entry receive FIFO advances on every read
// - start bit valid by vote 8-10 / 4-6
// - receive complete means unread data present
// - data register empty reads one after reset
`ifndef UAFD_DEFS_SVH
`define UAFD_DEFS_SVH

`define UAFD_SAMPLES_NORM 5'h10
`define UAFD_SAMPLES_DBL 5'h08
`define UAFD_VOTE_FIRST_NORM 5'h08
`define UAFD_VOTE_FIRST_DBL 5'h04
`define UAFD_VOTE_SPAN 5'h02
`define UAFD_SAMPLE_MID_NORM 5'h09
`define UAFD_SAMPLE_FIRST 5'h01
`define UAFD_SAMPLE_STEP 5'h01
`define UAFD_CHAR_9BIT 3'h7
`define UAFD_CHAR_BASE_BITS 4'h5
`define UAFD_NINE_BITS 4'h9
`define UAFD_NINTH_IDX 4'h8
`define UAFD_RXFIFO_DEPTH 2'h2

`define UAFD_OFS_CTRL 8'h00
`define UAFD_OFS_DIV 8'h04
`define UAFD_OFS_TXDATA 8'h08
`define UAFD_OFS_RXDATA 8'h0C
`define UAFD_OFS_STATUS 8'h10
`define UAFD_CTRL_RESET 4'h7
`define UAFD_DIV_RESET 16'h000F

`endif

//--- shared/uafd_pkg.sv
`include "uafd_defs.svh"
package uafd_pkg;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10,
        RX_STOP = 2'b11
    } uafd_rx_state_type;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_BITS = 2'b10
    } uafd_tx_state_type;

    typedef struct packed {
        logic fe;
        logic [8:0] data;
    } uafd_rx_entry_type;

    function automatic logic [3:0] uafd_data_bits(input logic [2:0] code);
        uafd_data_bits = (code == `UAFD_CHAR_9BIT) ? `UAFD_NINE_BITS :
            `UAFD_CHAR_BASE_BITS + {2'h0, code[1:0]};
    endfunction

    function automatic logic [8:0] uafd_char_mask(input logic [3:0] n);
        uafd_char_mask = ~(9'h1FF << n);
    endfunction

    function automatic logic uafd_majority(input logic a, input logic b, input logic c);
        uafd_majority = (a & b) | (a & c) | (b & c);
    endfunction

    // bit i after the start bit; stops are high unless ts puts the type bit in the first stop
    function automatic logic uafd_frame_bit(input logic [8:0] d, input logic [3:0] n,
                                            input logic [3:0] i, input logic ts);
        if (i < n) begin
            uafd_frame_bit = d[i];
        end else if (ts && i == n) begin
            uafd_frame_bit = d[`UAFD_NINTH_IDX];
        end else begin
            uafd_frame_bit = 1'b1;
        end
    endfunction
endpackage

//--- shared/uafd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uafd_if;
    logic dev_to_node;
    logic node_to_dev;
    modport device(output dev_to_node, input node_to_dev);
    modport node(input dev_to_node, output node_to_dev);
endinterface
`default_nettype wire

//--- verilog/uafd_node.sv
`timescale 1ns/1ps
`default_nettype none
`include "uafd_defs.svh"
module uafd_node (
    uafd_if.node link,
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp
);
    logic [3:0] ctrl_q;
    logic [15:0] div_q;
    logic [15:0] div_cnt_q;
    logic tick;
    logic [3:0] nbits;
    logic ap_take;
    logic ap_wr_q;
    logic [7:0] ap_addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdata_d;

    assign tick = (div_cnt_q == 16'h0000);
    assign nbits = uafd_pkg::uafd_data_bits(ctrl_q[2:0]);
    // only whole-word singles are issued, so hsize needs no decode
    assign ap_take = i_hsel && i_htrans[1] && i_hready && (i_hsize == 3'h2 || 1'b1);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || tick) begin
            div_cnt_q <= div_q;
        end else begin
            div_cnt_q <= div_cnt_q - 16'h0001;
        end
    end

    // transmitter: the first stop of a short frame carries the type bit
    uafd_pkg::uafd_tx_state_type tst_q;
    logic [8:0] tsh_q;
    logic [4:0] tsamp_q;
    logic [3:0] tbit_q;
    logic [3:0] tlast;
    logic txd_q;
    logic tx_start;
    logic ts;

    assign ts = (nbits != `UAFD_NINE_BITS);
    assign tlast = nbits + {3'h0, ctrl_q[3]};
    assign tx_start = ap_wr_q && (ap_addr_q == `UAFD_OFS_TXDATA) && (tst_q == uafd_pkg::TX_IDLE);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            tst_q <= uafd_pkg::TX_IDLE;
            tsh_q <= '0;
            tsamp_q <= `UAFD_SAMPLE_FIRST;
            tbit_q <= '0;
            txd_q <= 1'b1;
        end else if (tx_start) begin
            tst_q <= uafd_pkg::TX_START;
            tsh_q <= i_hwdata[8:0];
            tsamp_q <= `UAFD_SAMPLE_FIRST;
            txd_q <= 1'b0;
        end else if (tick) begin
            tsamp_q <= (tsamp_q == `UAFD_SAMPLES_NORM) ? `UAFD_SAMPLE_FIRST :
                tsamp_q + `UAFD_SAMPLE_STEP;
            if (tsamp_q == `UAFD_SAMPLES_NORM) begin
                unique case (tst_q)
                    uafd_pkg::TX_IDLE: begin
                        txd_q <= 1'b1;
                    end
                    uafd_pkg::TX_START: begin
                        tst_q <= uafd_pkg::TX_BITS;
                        tbit_q <= '0;
                        txd_q <= uafd_pkg::uafd_frame_bit(tsh_q, nbits, 4'h0, ts);
                    end
                    uafd_pkg::TX_BITS: begin
                        if (tbit_q == tlast) begin
                            tst_q <= uafd_pkg::TX_IDLE;
                        end else begin
                            tbit_q <= tbit_q + 4'h1;
                            txd_q <= uafd_pkg::uafd_frame_bit(tsh_q, nbits, tbit_q + 4'h1, ts);
                        end
                    end
                    default: begin
                        tst_q <= uafd_pkg::TX_IDLE;
                    end
                endcase
            end
        end
    end
    assign link.node_to_dev = txd_q;

    // receiver: one centre sample per bit, holding register of one frame
    uafd_pkg::uafd_rx_state_type rst_q;
    logic rx_prev_q;
    logic [4:0] rsamp_q;
    logic [3:0] rbit_q;
    logic [8:0] rsh_q;
    logic [8:0] rhold_q;
    logic rvalid_q;
    logic rfe_q;
    logic mid;
    logic rx_done;
    logic rx_pop;

    assign mid = tick && (rsamp_q == `UAFD_SAMPLE_MID_NORM);
    assign rx_done = mid && (rst_q == uafd_pkg::RX_STOP);
    assign rx_pop = ap_take && !i_hwrite && (i_haddr[7:0] == `UAFD_OFS_RXDATA);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rst_q <= uafd_pkg::RX_IDLE;
            rx_prev_q <= 1'b1;
            rsamp_q <= `UAFD_SAMPLE_FIRST;
            rbit_q <= '0;
            rsh_q <= '0;
        end else if (tick) begin
            rx_prev_q <= link.dev_to_node;
            rsamp_q <= (rsamp_q == `UAFD_SAMPLES_NORM) ? `UAFD_SAMPLE_FIRST :
                rsamp_q + `UAFD_SAMPLE_STEP;
            unique case (rst_q)
                uafd_pkg::RX_IDLE: begin
                    rsamp_q <= `UAFD_SAMPLE_FIRST + `UAFD_SAMPLE_STEP;
                    if (rx_prev_q && !link.dev_to_node) begin
                        rst_q <= uafd_pkg::RX_START;
                        rsh_q <= '0;
                        rbit_q <= '0;
                    end
                end
                uafd_pkg::RX_START: begin
                    if (mid) begin
                        rst_q <= link.dev_to_node ? uafd_pkg::RX_IDLE : uafd_pkg::RX_BITS;
                    end
                end
                uafd_pkg::RX_BITS: begin
                    if (mid) begin
                        rsh_q[rbit_q] <= link.dev_to_node;
                        if (rbit_q == nbits - 4'h1) begin
                            rst_q <= uafd_pkg::RX_STOP;
                        end else begin
                            rbit_q <= rbit_q + 4'h1;
                        end
                    end
                end
                uafd_pkg::RX_STOP: begin
                    if (mid) begin
                        rst_q <= uafd_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    // a frame landing with the clearing read keeps valid set
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rvalid_q <= 1'b0;
            rhold_q <= '0;
            rfe_q <= 1'b0;
        end else if (rx_done) begin
            rvalid_q <= 1'b1;
            rhold_q <= rsh_q;
            rfe_q <= !link.dev_to_node;
        end else if (rx_pop) begin
            rvalid_q <= 1'b0;
        end
    end

    // AHB-Lite slave, zero wait states
    always_comb begin
        case (i_haddr[7:0])
            `UAFD_OFS_CTRL: rdata_d = {28'h0, ctrl_q};
            `UAFD_OFS_DIV: rdata_d = {16'h0, div_q};
            `UAFD_OFS_RXDATA: rdata_d = {22'h0, rfe_q, rhold_q};
            `UAFD_OFS_STATUS: rdata_d = {29'h0, rfe_q, rvalid_q, tst_q != uafd_pkg::TX_IDLE};
            default: rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= '0;
            hrdata_q <= '0;
        end else begin
            ap_wr_q <= ap_take && i_hwrite;
            ap_addr_q <= i_haddr[7:0];
            if (ap_take && !i_hwrite) begin
                hrdata_q <= rdata_d;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ctrl_q <= `UAFD_CTRL_RESET;
            div_q <= `UAFD_DIV_RESET;
        end else if (ap_wr_q && ap_addr_q == `UAFD_OFS_CTRL) begin
            ctrl_q <= i_hwdata[3:0];
        end else if (ap_wr_q && ap_addr_q == `UAFD_OFS_DIV) begin
            div_q <= i_hwdata[15:0];
        end
    end

    assign o_hrdata = hrdata_q;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
endmodule
`default_nettype wire

//--- tb/uafd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module uafd_asserts (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_dev_to_node,
    input wire logic i_node_to_dev,
    input wire logic i_dp_wr,
    input wire logic i_dp_rd,
    input wire logic i_receive_complete,
    input wire logic i_data_reg_empty_flag,
    input wire logic i_transmit_complete_flag
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // a real start or data bit spans many sample ticks, so eight clocks is a safe floor
    sequence s_dev_low;
        !i_dev_to_node [*8];
    endsequence
    sequence s_node_low;
        !i_node_to_dev [*8];
    endsequence
    a_idle_after_reset: assert property (
        $fell(i_srst) |-> i_dev_to_node && i_node_to_dev && i_data_reg_empty_flag
        && !i_receive_complete) else $error("bad state after reset");
    a_write_takes_buf: assert property (
        i_dp_wr && i_data_reg_empty_flag |=> !i_data_reg_empty_flag)
        else $error("accepted write left buffer empty");
    a_load_starts_frame: assert property (
        $rose(i_data_reg_empty_flag) |-> s_dev_low) else $error("load without start bit");
    a_dev_bit_len: assert property (
        $fell(i_dev_to_node) |-> s_dev_low) else $error("serial out pulse too short");
    a_node_bit_len: assert property (
        $fell(i_node_to_dev) |-> s_node_low) else $error("node pulse too short");
    a_empty_fall_cause: assert property (
        $fell(i_data_reg_empty_flag) |-> $past(i_dp_wr)) else $error("buffer filled unasked");
    a_rxc_holds: assert property (
        i_receive_complete && !i_dp_rd |=> i_receive_complete) else $error("rxc lost unread");
    a_rxc_at_stop: assert property (
        $rose(i_receive_complete) |-> i_node_to_dev) else $error("rxc outside stop bit");
    a_txc_idle_line: assert property (
        $rose(i_transmit_complete_flag) |-> i_data_reg_empty_flag && i_dev_to_node)
        else $error("txc while busy");
endmodule
`default_nettype wire

//--- tb/uart_addr_filter_data_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module uart_addr_filter_data_port_tb_top;
    localparam int FR = 3100;
    logic clk, srst, dbl, stopsel, filt, wr, rd, n9, r9, rxc, udre, txc, fe, dor, hwrite, hrdy;
    logic [15:0] div;
    logic [2:0] csz;
    logic [7:0] wd, rdata;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic hresp;
    logic txen, txclr;
    int n_errors = 0;
    int n_checks = 0;
    uafd_if lnk();
    uafd_device u_uafd_device (.link(lnk.device), .i_sys_clk(clk), .i_srst(srst),
        .i_baud_divisor(div), .i_double_speed_select(dbl), .i_char_size_code(csz),
        .i_stop_bit_select(stopsel), .i_address_filter_mode(filt), .i_rx_en(1'b1),
        .i_tx_en(txen), .i_dp_wr(wr), .i_dp_wdata(wd), .i_tx_ninth_bit(n9), .i_dp_rd(rd),
        .i_txc_clear(txclr), .o_dp_rdata(rdata), .o_rx_ninth_bit(r9), .o_receive_complete(rxc),
        .o_data_reg_empty_flag(udre), .o_transmit_complete_flag(txc), .o_frame_error(fe),
        .o_data_overrun(dor));
    uafd_node u_uafd_node (.link(lnk.node), .i_sys_clk(clk), .i_srst(srst), .i_hsel(1'b1),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
        .o_hresp(hresp));
    uafd_asserts u_uafd_asserts (.i_sys_clk(clk), .i_srst(srst),
        .i_dev_to_node(lnk.dev_to_node), .i_node_to_dev(lnk.node_to_dev), .i_dp_wr(wr),
        .i_dp_rd(rd), .i_receive_complete(rxc), .i_data_reg_empty_flag(udre),
        .i_transmit_complete_flag(txc));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // waits on hready are cut short only by the watchdog
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic send(input logic [31:0] d);
        ahb(1'b1, 8'h08, d);
        wt(FR);
    endtask
    task automatic pop();
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        wt(2);
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        {srst, dbl, stopsel, wr, rd, n9, hwrite} = 7'h40;
        filt = 1'b1;
        txen = 1'b1;
        txclr = 1'b0;
        div = 16'h000F;
        csz = 3'h7;
        wd = 8'h00;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        wt(2);
        chk({udre, rxc}, 32'h2);
        send(32'h1A5);
        chk({rxc, r9, rdata}, 32'h3A5);
        pop();
        send(32'h033);
        chk({rxc, fe, dor}, 32'h0);
        filt <= 1'b0;
        send(32'h055);
        send(32'h0AA);
        send(32'h0CC);
        chk({dor, rxc, r9, rdata}, 32'h655);
        pop();
        chk({dor, rxc, r9, rdata}, 32'h2AA);
        pop();
        chk(rxc, 32'h0);
        filt <= 1'b1;
        @(posedge clk);
        wr <= 1'b1;
        n9 <= 1'b1;
        wd <= 8'hC3;
        @(posedge clk);
        wd <= 8'h3C;
        @(posedge clk);
        wr <= 1'b0;
        wt(FR);
        ahb(1'b0, 8'h0C, 32'h0);
        chk(q, 32'h1C3);
        wt(FR);
        ahb(1'b0, 8'h10, 32'h0);
        chk({txc, q[1:0]}, 32'h4);
        txclr <= 1'b1;
        txen <= 1'b0;
        @(posedge clk);
        txclr <= 1'b0;
        wr <= 1'b1;
        wd <= 8'h5A;
        @(posedge clk);
        wr <= 1'b0;
        wt(4);
        chk({txc, udre}, 32'h0);
        txen <= 1'b1;
        wt(4);
        chk(udre, 32'h1);
        wt(FR);
        csz <= 3'h0;
        stopsel <= 1'b1;
        ahb(1'b1, 8'h00, 32'h8);
        send(32'h0FF);
        chk(rxc, 32'h0);
        send(32'h1FF);
        chk({rxc, rdata}, 32'h11F);
        pop();
        @(posedge clk);
        wr <= 1'b1;
        wd <= 8'hFF;
        @(posedge clk);
        wr <= 1'b0;
        wt(FR);
        ahb(1'b0, 8'h0C, 32'h0);
        chk(q, 32'h01F);
        csz <= 3'h7;
        dbl <= 1'b1;
        div <= 16'h001F;
        filt <= 1'b0;
        ahb(1'b1, 8'h00, 32'h7);
        send(32'h099);
        chk({rxc, r9, rdata}, 32'h299);
        ahb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        chk(hresp, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
